// ===== rtl/pp_byte_buf.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module pp_byte_buf (
	input wire logic core_clk,
	input wire logic sys_rst,
	pp_stream_if.snk fill,
	pp_stream_if.src drain
);
	logic [ppt_pkg::BYTE_W-1:0] mem_r [ppt_pkg::BUF_DEPTH];
	logic [ppt_pkg::BUF_AW-1:0] wptr_r;
	logic [ppt_pkg::BUF_AW-1:0] rptr_r;
	logic [ppt_pkg::BUF_AW:0] cnt_r;
	wire push = fill.valid & fill.ready;
	wire pop = drain.valid & drain.ready;

	assign fill.ready = (cnt_r != ppt_pkg::BUF_FULL_CNT);
	assign drain.valid = (cnt_r != '0);
	assign drain.data = mem_r[rptr_r];

	for (genvar i = 0; i < ppt_pkg::BUF_DEPTH; i++) begin : g_entry
		localparam logic [ppt_pkg::BUF_AW-1:0] IDX = ppt_pkg::BUF_AW'(i);
		always_ff @(posedge core_clk) begin
			if (push && wptr_r == IDX) begin
				mem_r[i] <= fill.data;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wptr_r <= wptr_r + 1'b1;
			if (pop) rptr_r <= rptr_r + 1'b1;
			if (push && !pop) cnt_r <= cnt_r + 1'b1;
			else if (pop && !push) cnt_r <= cnt_r - 1'b1;
		end
	end

	a_buf_fill_count: assert property (@(posedge core_clk) disable iff (sys_rst)
		(push && !pop) |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("buffer count did not rise on push");

	a_buf_full_refuse: assert property (@(posedge core_clk) disable iff (sys_rst)
		cnt_r == ppt_pkg::BUF_FULL_CNT |-> !fill.ready ##1 wptr_r == $past(wptr_r))
		else $error("buffer took a byte while full");
endmodule

// ===== rtl/pp_stream_if.sv
// valid/ready byte stream between the write capture and the bus latch
`timescale 1ns/1ps
interface pp_stream_if;
	logic valid;
	logic ready;
	logic [ppt_pkg::BYTE_W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ===== rtl/ppt_pkg.sv
// constants shared by the printer parallel port and its write buffer
// How it works
// - port select low enables access; strobes are ignored while it is high.
// - read selects 00 data, 01 status, 10 control; write 00 data, 10 control.
// - data read returns present levels of the eight parallel bus lines.
// - status bits 7..2 busy, ack, paper, online, error, irq; bits 1..0 one.
// - acknowledge input is sampled and reported in status bit 6.
// - control write sets direction, irq enable, select-in, init, autofeed, strobe.
// - control read returns those six settings, bits 7 and 6 zero.
// - data write latches the byte and drives it onto the parallel bus.
// - strobe output follows the control setting exactly, marking a valid byte.
package ppt_pkg;
	localparam int BYTE_W = 8;
	localparam int STAT_W = 6;
	localparam int CTRL_W = 6;
	localparam int BUF_DEPTH = 2;
	localparam int BUF_AW = 1;
	localparam logic [BUF_AW:0] BUF_FULL_CNT = 2'h2;
	localparam logic [1:0] RSEL_DATA = 2'h0;
	localparam logic [1:0] RSEL_STAT = 2'h1;
	localparam logic [1:0] RSEL_CTRL = 2'h2;
	// control field positions
	localparam int CB_STB = 0;
	localparam int CB_AFD = 1;
	localparam int CB_INIT = 2;
	localparam int CB_SELIN = 3;
	localparam int CB_IEN = 4;
	localparam int CB_DIR = 5;
	// status field positions within the six-bit status group
	localparam int SB_PIRQ = 0;
	localparam int SB_ERR = 1;
	localparam int SB_ONLINE = 2;
	localparam int SB_PAPER = 3;
	localparam int SB_ACK = 4;
	localparam int SB_BUSY = 5;
	localparam logic [1:0] STAT_LOW_ONES = 2'h3;
	localparam logic [1:0] CTRL_HIGH_ZERO = 2'h0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam logic [BYTE_W-1:0] OUT_BYTE_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] RD_BYTE_RESET = 8'h00;
	localparam int PIN_W = STAT_W + 2 * BYTE_W + 5;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_ACTIVE = 2'h1,
		WR_COMMIT = 2'h3
	} wr_state_t;
endpackage

// ===== rtl/printer_parallel_port.sv
// printer parallel port: host register access, printer control and bus drive
`timescale 1ns/1ps
module printer_parallel_port (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic port_select_n,
	input wire logic host_read_n,
	input wire logic host_write_n,
	input wire logic reg_sel_hi,
	input wire logic reg_sel_lo,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_n,
	output logic port_ready,
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe_n,
	input wire logic printer_busy_flag,
	input wire logic printer_ack,
	input wire logic paper_out_flag,
	input wire logic printer_online_flag,
	input wire logic printer_error,
	input wire logic printer_irq,
	output logic byte_valid_pulse,
	output logic auto_linefeed_line,
	output logic init_printer_line,
	output logic select_in_line,
	output logic port_irq
);
	// every pin arrives from outside the clock domain
	logic [ppt_pkg::PIN_W-1:0] pin_meta_r;
	logic [ppt_pkg::PIN_W-1:0] pin_sync_r;
	wire [ppt_pkg::PIN_W-1:0] pin_raw = {
		printer_busy_flag, printer_ack, paper_out_flag,
		printer_online_flag, printer_error, printer_irq,
		bus_data_in, host_data_in,
		port_select_n, host_read_n, host_write_n, reg_sel_hi, reg_sel_lo
	};

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	wire [ppt_pkg::STAT_W-1:0] status_s = pin_sync_r[26:21];
	wire [7:0] bus_in_s = pin_sync_r[20:13];
	wire [7:0] host_in_s = pin_sync_r[12:5];
	wire sel_s = ~pin_sync_r[4];
	wire rd_s = ~pin_sync_r[3];
	wire wr_s = ~pin_sync_r[2];
	wire [1:0] rsel_s = pin_sync_r[1:0];

	// read decode
	wire rd_act = sel_s & rd_s & ~wr_s;
	wire rd_data_hit = rd_act && rsel_s == ppt_pkg::RSEL_DATA;
	wire rd_stat_hit = rd_act && rsel_s == ppt_pkg::RSEL_STAT;
	wire rd_ctrl_hit = rd_act && rsel_s == ppt_pkg::RSEL_CTRL;
	wire rd_valid = rd_data_hit | rd_stat_hit | rd_ctrl_hit;

	logic [ppt_pkg::CTRL_W-1:0] ctrl_r;
	wire [7:0] stat_word = {status_s, ppt_pkg::STAT_LOW_ONES};
	wire [7:0] ctrl_word = {ppt_pkg::CTRL_HIGH_ZERO, ctrl_r};
	wire [7:0] rd_mux = rd_stat_hit ? stat_word :
		rd_ctrl_hit ? ctrl_word : bus_in_s;

	logic [7:0] host_data_out_r;
	logic host_data_oe_n_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_data_out_r <= ppt_pkg::RD_BYTE_RESET;
			host_data_oe_n_r <= 1'b1;
		end else begin
			// live sampling while the strobe stays low, like a transparent path
			if (rd_valid) host_data_out_r <= rd_mux;
			host_data_oe_n_r <= ~rd_valid;
		end
	end

	assign host_data_out = host_data_out_r;
	assign host_data_oe_n = host_data_oe_n_r;

	// write capture: commit on the trailing edge of the write strobe
	ppt_pkg::wr_state_t wr_state_r;
	ppt_pkg::wr_state_t wr_state_nxt;
	logic [7:0] wr_hold_r;
	logic [1:0] wr_sel_r;
	wire wr_act = sel_s & wr_s & ~rd_s;
	wire commit = (wr_state_r == ppt_pkg::WR_COMMIT);
	wire data_wr_fire = commit && wr_sel_r == ppt_pkg::RSEL_DATA;
	wire ctrl_wr_fire = commit && wr_sel_r == ppt_pkg::RSEL_CTRL;

	pp_stream_if wr_fill ();
	pp_stream_if wr_drain ();

	assign wr_fill.valid = data_wr_fire;
	assign wr_fill.data = wr_hold_r;
	// bus byte must not change under an active strobe, so drain waits
	assign wr_drain.ready = ~ctrl_r[ppt_pkg::CB_STB];
	assign port_ready = wr_fill.ready;

	pp_byte_buf u_wr_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.fill(wr_fill.snk),
		.drain(wr_drain.src)
	);

	always_comb begin
		wr_state_nxt = wr_state_r;
		case (wr_state_r)
			ppt_pkg::WR_IDLE: begin
				if (wr_act) wr_state_nxt = ppt_pkg::WR_ACTIVE;
			end
			ppt_pkg::WR_ACTIVE: begin
				if (!wr_act) wr_state_nxt = ppt_pkg::WR_COMMIT;
			end
			ppt_pkg::WR_COMMIT: begin
				// a full buffer holds the commit so the byte is not lost
				if (!data_wr_fire || wr_fill.ready) wr_state_nxt = ppt_pkg::WR_IDLE;
			end
			default: wr_state_nxt = ppt_pkg::WR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_state_r <= ppt_pkg::WR_IDLE;
			wr_hold_r <= ppt_pkg::OUT_BYTE_RESET;
			wr_sel_r <= ppt_pkg::RSEL_DATA;
		end else begin
			wr_state_r <= wr_state_nxt;
			if (wr_act && wr_state_r != ppt_pkg::WR_COMMIT) begin
				wr_hold_r <= host_in_s;
				wr_sel_r <= rsel_s;
			end
		end
	end

	// control register and bus byte latch
	logic [7:0] out_byte_r;
	logic bus_data_oe_n_r;
	logic port_irq_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= ppt_pkg::CTRL_RESET;
		end else if (ctrl_wr_fire) begin
			ctrl_r <= wr_hold_r[ppt_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_byte_r <= ppt_pkg::OUT_BYTE_RESET;
			bus_data_oe_n_r <= 1'b1;
			port_irq_r <= 1'b0;
		end else begin
			if (wr_drain.valid && wr_drain.ready) out_byte_r <= wr_drain.data;
			bus_data_oe_n_r <= ctrl_r[ppt_pkg::CB_DIR];
			port_irq_r <= ctrl_r[ppt_pkg::CB_IEN] & status_s[ppt_pkg::SB_PIRQ];
		end
	end

	assign bus_data_out = out_byte_r;
	assign bus_data_oe_n = bus_data_oe_n_r;
	assign port_irq = port_irq_r;
	assign byte_valid_pulse = ctrl_r[ppt_pkg::CB_STB];
	assign auto_linefeed_line = ctrl_r[ppt_pkg::CB_AFD];
	assign init_printer_line = ctrl_r[ppt_pkg::CB_INIT];
	assign select_in_line = ctrl_r[ppt_pkg::CB_SELIN];

	// checks
	a_deselect_no_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
		!sel_s |=> host_data_oe_n)
		else $error("host bus driven while port not selected");

	a_deselect_no_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_state_r == ppt_pkg::WR_IDLE && !sel_s) |=> wr_state_r == ppt_pkg::WR_IDLE)
		else $error("write captured while port not selected");

	a_invalid_read_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_act && rsel_s == 2'h3) |=> host_data_oe_n)
		else $error("invalid read address drove the host bus");

	a_read_bus_levels: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_data_hit |=> !host_data_oe_n && host_data_out == $past(bus_in_s))
		else $error("data read did not return bus levels");

	a_status_layout: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_stat_hit |=> host_data_out[1:0] == 2'h3 && host_data_out[7:2] == $past(status_s))
		else $error("status read layout wrong");

	// two sync edges plus the read register: bit 6 shows the pin of three edges back
	a_ack_reported: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_stat_hit |=> host_data_out[6] == $past(printer_ack, 3))
		else $error("acknowledge level not reported in bit 6");

	a_ctrl_write_lines: assert property (@(posedge core_clk) disable iff (sys_rst)
		ctrl_wr_fire |=> {bus_data_oe_n_r, select_in_line, init_printer_line} ==
			{bus_data_oe_n_r, $past(wr_hold_r[3:2])} ##1
			bus_data_oe_n == $past(wr_hold_r[5], 2))
		else $error("control write did not set the lines");

	a_ctrl_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_ctrl_hit |=> host_data_out == {2'h0, $past(ctrl_r)})
		else $error("control readback mismatch");

	a_write_drives_bus: assert property (@(posedge core_clk) disable iff (sys_rst)
		(data_wr_fire && wr_fill.ready && !wr_drain.valid && !byte_valid_pulse)
			|=> ##1 bus_data_out == $past(wr_hold_r, 2))
		else $error("written byte not latched onto bus");

	a_strobe_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
		ctrl_wr_fire |=> byte_valid_pulse == $past(wr_hold_r[0]))
		else $error("strobe line does not follow control write");

	a_dir_release: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(ctrl_r[ppt_pkg::CB_DIR]) |=> bus_data_oe_n)
		else $error("bus still driven after direction set");

	a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		!ctrl_r[ppt_pkg::CB_IEN] |=> !port_irq)
		else $error("port irq raised while disabled");
endmodule

// ===== verif/printer_model.sv
// printer side model: status levels, bus drive when released, ack after strobe
`timescale 1ns/1ps
module printer_model (
	input wire logic core_clk,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe_n,
	input wire logic byte_valid_pulse,
	input wire logic ext_en,
	input wire logic [7:0] ext_byte,
	input wire logic [5:0] stat_set,
	input wire logic [3:0] ack_delay,
	output logic [7:0] bus_level,
	output logic [5:0] stat_lines,
	output logic [7:0] taken_byte
);
	logic [7:0] float_r = 8'h00;
	logic [15:0] stb_hist = 16'h0000;
	// no pull-ups: an undriven bus shows the inverse of its last driven level
	assign bus_level = !bus_data_oe_n ? bus_data_out : (ext_en ? ext_byte : float_r);
	// ack answers a strobe after a chosen delay, prompt or slow
	assign stat_lines = {stat_set[5], stat_set[4] | stb_hist[ack_delay], stat_set[3:0]};
	always @(posedge core_clk) begin
		if (!bus_data_oe_n) float_r <= ~bus_data_out;
		stb_hist <= {stb_hist[14:0], byte_valid_pulse};
	end
	initial taken_byte = 8'h00;
	always @(posedge byte_valid_pulse) begin
		taken_byte = bus_level;
	end
endmodule

// ===== verif/printer_parallel_port_tb.sv
// register-level testbench of the printer parallel port
`timescale 1ns/1ps
module printer_parallel_port_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic port_select_n = 1'b1;
	logic host_read_n = 1'b1;
	logic host_write_n = 1'b1;
	logic [1:0] rsel = 2'h0;
	logic [7:0] host_data_in = 8'h00;
	logic ext_en = 1'b0;
	logic [7:0] ext_byte = 8'h00;
	logic [5:0] stat_set = 6'h00;
	logic [3:0] ack_delay = 4'h2;
	logic [7:0] host_data_out, bus_data_out, bus_level, taken_byte;
	logic [5:0] stat_lines;
	logic host_data_oe_n, port_ready, bus_data_oe_n, port_irq;
	logic byte_valid_pulse, auto_linefeed_line, init_printer_line, select_in_line;
	int mismatches = 0;
	int n_compared = 0;
	always #4 core_clk = ~core_clk;
	printer_parallel_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.port_select_n(port_select_n), .host_read_n(host_read_n),
		.host_write_n(host_write_n), .reg_sel_hi(rsel[1]), .reg_sel_lo(rsel[0]),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .port_ready(port_ready),
		.bus_data_in(bus_level), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
		.printer_busy_flag(stat_lines[5]), .printer_ack(stat_lines[4]),
		.paper_out_flag(stat_lines[3]), .printer_online_flag(stat_lines[2]),
		.printer_error(stat_lines[1]), .printer_irq(stat_lines[0]),
		.byte_valid_pulse(byte_valid_pulse), .auto_linefeed_line(auto_linefeed_line),
		.init_printer_line(init_printer_line), .select_in_line(select_in_line),
		.port_irq(port_irq));
	printer_model i_printer (.core_clk(core_clk), .bus_data_out(bus_data_out),
		.bus_data_oe_n(bus_data_oe_n), .byte_valid_pulse(byte_valid_pulse),
		.ext_en(ext_en), .ext_byte(ext_byte), .stat_set(stat_set), .ack_delay(ack_delay),
		.bus_level(bus_level), .stat_lines(stat_lines), .taken_byte(taken_byte));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// strobes held 4 cycles so the synchronised level is surely seen
	task automatic host_wr(input logic sel_n, input logic [1:0] a, input logic [7:0] d);
		int k;
		k = 0;
		// only a data write can be held by a full buffer
		while (a == ppt_pkg::RSEL_DATA && port_ready !== 1'b1 && k < 50) begin
			cyc(1);
			k++;
		end
		port_select_n = sel_n;
		rsel = a;
		host_data_in = d;
		host_write_n = 1'b0;
		cyc(4);
		host_write_n = 1'b1;
		cyc(1);
		port_select_n = 1'b1;
		cyc(7);
	endtask
	task automatic host_rd(input logic [1:0] a, input logic [7:0] exp, input logic drive);
		port_select_n = 1'b0;
		rsel = a;
		host_read_n = 1'b0;
		cyc(5);
		check({7'h00, host_data_oe_n}, {7'h00, !drive});
		if (drive) begin
			check(host_data_out, exp);
		end
		host_read_n = 1'b1;
		port_select_n = 1'b1;
		cyc(5);
		check({7'h00, host_data_oe_n}, 8'h01);
	endtask
	task automatic test_done;
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge core_clk);
		mismatches++;
		test_done();
	end
	initial begin
		cyc(2);
		sys_rst = 1'b0;
		cyc(2);
		host_rd(ppt_pkg::RSEL_CTRL, 8'h00, 1'b1);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'hce);
		check({4'h0, select_in_line, init_printer_line, auto_linefeed_line,
			byte_valid_pulse}, 8'h0e);
		host_rd(ppt_pkg::RSEL_CTRL, 8'h0e, 1'b1);
		// refused writes must leave control untouched
		host_wr(1'b1, ppt_pkg::RSEL_CTRL, 8'h01);
		host_wr(1'b0, 2'h1, 8'h01);
		host_wr(1'b0, 2'h3, 8'h01);
		host_rd(ppt_pkg::RSEL_CTRL, 8'h0e, 1'b1);
		host_rd(2'h3, 8'h00, 1'b0);
		host_wr(1'b0, ppt_pkg::RSEL_DATA, 8'ha5);
		check(bus_data_out, 8'ha5);
		check({7'h00, bus_data_oe_n}, 8'h00);
		host_rd(ppt_pkg::RSEL_DATA, 8'ha5, 1'b1);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h01);
		check(taken_byte, 8'ha5);
		host_rd(ppt_pkg::RSEL_STAT, 8'h43, 1'b1);
		// two bytes queue while strobe stands; the bus must not move
		host_wr(1'b0, ppt_pkg::RSEL_DATA, 8'h11);
		host_wr(1'b0, ppt_pkg::RSEL_DATA, 8'h22);
		check(bus_data_out, 8'ha5);
		check({7'h00, port_ready}, 8'h00);
		ack_delay = 4'h9;
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h00);
		cyc(6);
		check(bus_data_out, 8'h22);
		check({7'h00, port_ready}, 8'h01);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h01);
		check(taken_byte, 8'h22);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h00);
		cyc(12);
		for (int i = 0; i < 6; i++) begin
			stat_set = 6'h01 << i;
			cyc(3);
			host_rd(ppt_pkg::RSEL_STAT, {stat_set, 2'h3}, 1'b1);
		end
		stat_set = 6'h01;
		cyc(4);
		check({7'h00, port_irq}, 8'h00);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h10);
		check({7'h00, port_irq}, 8'h01);
		stat_set = 6'h00;
		cyc(4);
		check({7'h00, port_irq}, 8'h00);
		ext_en = 1'b1;
		ext_byte = 8'h5a;
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h20);
		check({7'h00, bus_data_oe_n}, 8'h01);
		host_rd(ppt_pkg::RSEL_DATA, 8'h5a, 1'b1);
		ext_en = 1'b0;
		cyc(3);
		host_rd(ppt_pkg::RSEL_DATA, 8'hdd, 1'b1);
		host_wr(1'b0, ppt_pkg::RSEL_CTRL, 8'h00);
		host_rd(ppt_pkg::RSEL_DATA, 8'h22, 1'b1);
		test_done();
	end
endmodule
